// file: src/motor_capture_timer_defs.svh
// Register map, field positions and reset values of the capture timer.
// Assumes byte-wide registers on a 3-bit register index.
`ifndef MOTOR_CAPTURE_TIMER_DEFS_SVH
`define MOTOR_CAPTURE_TIMER_DEFS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ADDR_TIMER_CONTROL_0   3'h0
`define ADDR_TIMER_CONTROL_1   3'h1
`define ADDR_COUNTER_LOW_BYTE  3'h2
`define ADDR_COUNTER_HIGH_BYTE 3'h3
`define ADDR_COMPARE_LOW_BYTE  3'h4
`define ADDR_COMPARE_HIGH_BYTE 3'h5
`define ADDR_CAPTURE_LOW_BYTE  3'h6
`define ADDR_CAPTURE_HIGH_BYTE 3'h7

// ----------------------------------------------------------------
// timer_control_0 fields
// ----------------------------------------------------------------
`define BIT_COUNTER_PAUSE      7
`define MSB_COUNTER_CLOCK_SEL  6
`define LSB_COUNTER_CLOCK_SEL  4
`define BIT_TIMER_ON           3
`define MSB_CAPTURE_SOURCE_SEL 1
`define LSB_CAPTURE_SOURCE_SEL 0
`define CONTROL_0_WRITE_MASK   8'hfb

// ----------------------------------------------------------------
// timer_control_1 fields
// ----------------------------------------------------------------
`define MSB_CAPTURE_EDGE_SEL   7
`define LSB_CAPTURE_EDGE_SEL   6
`define BIT_CAPTURE_INPUT_EN   5
`define BIT_FILTER_SAMPLE_CNT  4
`define BIT_FILTER_CLOCK_SEL   3
`define BIT_FILTER_ENABLE      2
`define BIT_CAPTURE_AUTO_CLEAR 1
`define BIT_MATCH_AUTO_CLEAR   0

// ----------------------------------------------------------------
// Codes, reset values and timing
// ----------------------------------------------------------------
`define CLOCK_SEL_PWM          3'h0
`define EDGE_RISING            2'h1
`define EDGE_FALLING           2'h2
`define EDGE_BOTH              2'h3
`define REG_RESET_VALUE        8'h00
`define COUNTER_MAX            16'hffff
`define FILTER_SLOW_PHASE      2'h3

`endif

// file: src/motor_capture_timer_pkg.sv
// Types of the capture timer: the whole register state as one struct.
// Assumes the constants header is included by the design file.
package motor_capture_timer_pkg;

    typedef struct packed {
        logic [7:0]  ctl0;
        logic [7:0]  ctl1;
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic [15:0] cap;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic        pwm_prev;
        logic [6:0]  presc;
        logic [1:0]  fdiv;
        logic [2:0]  fhist;
        logic        flevel;
        logic        cond_prev;
        logic [7:0]  rdata;
        logic        match;
        logic        ovf;
    } state_s;

endpackage

// file: src/motor_capture_timer.sv
// Capture/compare timer for motor control with byte register port.
// Assumes async Hall, capture pin and PWM period inputs; one clock.
//
// Behaviour
// - 16-bit up-counter compared against compare value
// - Clock select: PWM period or sysclk/2..128
// - Pause holds count except on capture auto-clear; resume from held value
// - timer_on rise clears, fall stops and holds
// - Capture source: Hall A, B, C, pin
// - Edge select: off, rising, falling, both
// - Capture only while capture input enabled
// - Filter needs 2 or 4 equal samples
// - Filter samples at sysclk or sysclk/4
// - Filter active only when on and enabled
// - Valid capture edge copies counter to capture
// - Capture auto-clear zeroes counter after copy while timer on
// - Match auto-clear zeroes counter on match
// - Compare value zero still matches
// - Counter, capture read-only; compare read/write
// - Control 0 bit 2 reads zero
// - Controls and counter reset to zero
// - Match sets compare match flag
// - Overflow sets overflow flag
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "motor_capture_timer_defs.svh"

module motor_capture_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    // Capture and clock sources
    input  wire logic       hall_a_filtered,
    input  wire logic       hall_b_filtered,
    input  wire logic       hall_c_filtered,
    input  wire logic       capture_pin_input,
    input  wire logic       pwm_period_signal,
    // Event pulses
    output logic            compare_match_flag,
    output logic            overflow_flag
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    motor_capture_timer_pkg::state_s q;
    motor_capture_timer_pkg::state_s d;

    logic       timer_on;
    logic       pause;
    logic [2:0] clk_sel;
    logic [1:0] src_sel;
    logic [1:0] edge_sel;
    logic       cap_en;
    logic       filt_four;
    logic       filt_slow;
    logic       filt_en;
    logic       cap_auto;
    logic       match_auto;
    logic       tick;
    logic       run;
    logic       cap_evt;
    logic       match_evt;
    logic       clr;
    logic       ctl0_wr;
    logic       on_rise;
    logic       src_now;

    assign timer_on   = q.ctl0[`BIT_TIMER_ON];
    assign pause      = q.ctl0[`BIT_COUNTER_PAUSE];
    assign clk_sel    = q.ctl0[`MSB_COUNTER_CLOCK_SEL:`LSB_COUNTER_CLOCK_SEL];
    assign src_sel    = q.ctl0[`MSB_CAPTURE_SOURCE_SEL:`LSB_CAPTURE_SOURCE_SEL];
    assign edge_sel   = q.ctl1[`MSB_CAPTURE_EDGE_SEL:`LSB_CAPTURE_EDGE_SEL];
    assign cap_en     = q.ctl1[`BIT_CAPTURE_INPUT_EN];
    assign filt_four  = q.ctl1[`BIT_FILTER_SAMPLE_CNT];
    assign filt_slow  = q.ctl1[`BIT_FILTER_CLOCK_SEL];
    assign filt_en    = q.ctl1[`BIT_FILTER_ENABLE];
    assign cap_auto   = q.ctl1[`BIT_CAPTURE_AUTO_CLEAR];
    assign match_auto = q.ctl1[`BIT_MATCH_AUTO_CLEAR];
    assign src_now    = q.sync2[src_sel];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] mask;
        logic       raw;
        logic       samp;
        logic       agree;
        logic       cond;
        logic       rise;
        logic       fall;
        logic [7:0] rd;
        mask  = 8'h00;
        raw   = 1'b0;
        samp  = 1'b0;
        agree = 1'b0;
        cond  = 1'b0;
        rise  = 1'b0;
        fall  = 1'b0;
        rd    = 8'h00;
        d     = q;

        // Two-flop synchronisers; only sync2 feeds logic
        d.sync1 = {pwm_period_signal, capture_pin_input,
                   hall_c_filtered, hall_b_filtered, hall_a_filtered};
        d.sync2 = q.sync1;
        d.pwm_prev = q.sync2[4];

        // Free-running prescaler; divide by 2^k ticks on low k bits all ones
        d.presc = q.presc + 7'h1;
        mask = (8'h01 << clk_sel) - 8'h01;
        if (clk_sel == `CLOCK_SEL_PWM) begin
            tick = q.sync2[4] & ~q.pwm_prev;
        end else begin
            tick = (({1'b0, q.presc} & mask) == mask);
        end

        // Source mux
        raw = q.sync2[src_sel];

        // Noise filter: level accepted after 2 or 4 equal samples
        d.fdiv = q.fdiv + 2'h1;
        samp = filt_slow ? (q.fdiv == `FILTER_SLOW_PHASE) : 1'b1;
        agree = filt_four ? (q.fhist == {3{raw}}) : (q.fhist[0] == raw);
        if (samp) begin
            d.fhist = {q.fhist[1:0], raw};
            if (agree) begin
                d.flevel = raw;
            end
        end
        // Bypass unless timer on and filter enabled
        cond = (timer_on & filt_en) ? q.flevel : raw;

        // Edge detect on conditioned signal, one event per edge
        d.cond_prev = cond;
        rise = cond & ~q.cond_prev;
        fall = ~cond & q.cond_prev;
        cap_evt = cap_en & (((edge_sel == `EDGE_RISING) & rise) |
                            ((edge_sel == `EDGE_FALLING) & fall) |
                            ((edge_sel == `EDGE_BOTH) & (rise | fall)));
        if (cap_evt) begin
            d.cap = q.cnt;
        end

        // Counting, compare and overflow
        run = timer_on & ~pause;
        // Equality checked on the counting tick, so zero also matches
        match_evt = run & tick & (q.cnt == q.cmp);
        clr = timer_on & ((cap_evt & cap_auto) | (match_evt & match_auto));
        d.match = match_evt;
        d.ovf = run & tick & (q.cnt == `COUNTER_MAX) & ~clr;
        if (clr) begin
            d.cnt = 16'h0000;
        end else if (run & tick) begin
            d.cnt = q.cnt + 16'h0001;
        end

        // Register writes; counter and capture are not writable
        ctl0_wr = wr_en & (addr == `ADDR_TIMER_CONTROL_0);
        on_rise = ctl0_wr & ~timer_on & wdata[`BIT_TIMER_ON];
        if (wr_en) begin
            case (addr)
                `ADDR_TIMER_CONTROL_0:   d.ctl0 = wdata & `CONTROL_0_WRITE_MASK;
                `ADDR_TIMER_CONTROL_1:   d.ctl1 = wdata;
                `ADDR_COMPARE_LOW_BYTE:  d.cmp[7:0] = wdata;
                `ADDR_COMPARE_HIGH_BYTE: d.cmp[15:8] = wdata;
                default: ;
            endcase
        end
        if (on_rise) begin
            d.cnt = 16'h0000;
        end

        // Read data valid only in the cycle after the strobe
        case (addr)
            `ADDR_TIMER_CONTROL_0:   rd = q.ctl0;
            `ADDR_TIMER_CONTROL_1:   rd = q.ctl1;
            `ADDR_COUNTER_LOW_BYTE:  rd = q.cnt[7:0];
            `ADDR_COUNTER_HIGH_BYTE: rd = q.cnt[15:8];
            `ADDR_COMPARE_LOW_BYTE:  rd = q.cmp[7:0];
            `ADDR_COMPARE_HIGH_BYTE: rd = q.cmp[15:8];
            `ADDR_CAPTURE_LOW_BYTE:  rd = q.cap[7:0];
            `ADDR_CAPTURE_HIGH_BYTE: rd = q.cap[15:8];
            default:                 rd = 8'h00;
        endcase
        d.rdata = rd_en ? rd : 8'h00;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // All state resets to zero, timer off and capture disabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rdata              = q.rdata;
    assign compare_match_flag = q.match;
    assign overflow_flag      = q.ovf;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    count_step_a: assert property (
        run && tick && !clr && !ctl0_wr |=> q.cnt == $past(q.cnt) + 16'h0001)
        else $error("counter did not advance on tick");

    div_two_a: assert property (
        clk_sel == 3'h1 && tick && !ctl0_wr |=> !tick ##1 (tick || clk_sel != 3'h1))
        else $error("divide-by-two tick spacing wrong");

    pause_hold_a: assert property (
        timer_on && pause && !ctl0_wr |=> q.cnt == $past(q.cnt))
        else $error("paused counter moved");

    on_rise_clear_a: assert property (
        on_rise |=> q.cnt == 16'h0000 && timer_on)
        else $error("timer on did not clear counter");

    off_hold_a: assert property (
        !timer_on && !ctl0_wr |=> q.cnt == $past(q.cnt))
        else $error("stopped counter moved");

    cap_gate_a: assert property (
        !cap_en |-> !cap_evt)
        else $error("capture while input disabled");

    cap_copy_a: assert property (
        cap_evt |=> q.cap == $past(q.cnt))
        else $error("capture value wrong");

    cap_clear_a: assert property (
        cap_evt && cap_auto && timer_on && !ctl0_wr |=> q.cnt == 16'h0000)
        else $error("capture auto-clear failed");

    match_clear_a: assert property (
        match_evt && match_auto && !ctl0_wr |=> q.cnt == 16'h0000 && compare_match_flag)
        else $error("match auto-clear failed");

    match_flag_a: assert property (
        compare_match_flag |-> $past(q.cnt) == $past(q.cmp) && $past(run))
        else $error("match flag without equality");

    ovf_wrap_a: assert property (
        overflow_flag |-> $past(q.cnt) == 16'hffff && q.cnt == 16'h0000)
        else $error("overflow flag without wrap");

    bit2_zero_a: assert property (
        rd_en && addr == 3'h0 |=> rdata[2] == 1'b0 ##1 (rdata == 8'h00 || $past(rd_en)))
        else $error("control bit 2 or idle read data nonzero");

    // ----------------------------------------------------------------
    // Assertions: filter, edges, counter, reset and register port
    // ----------------------------------------------------------------

    filt_bypass_a: assert property (
        !(timer_on && filt_en) |=> q.cond_prev == $past(src_now))
        else $error("unfiltered source not passed to edge stage");

    filt_on_a: assert property (
        timer_on && filt_en |=> q.cond_prev == $past(q.flevel))
        else $error("filtered level not passed to edge stage");

    filt_two_a: assert property (
        !filt_four && q.fhist[0] != src_now |=> q.flevel == $past(q.flevel))
        else $error("filter took a single sample");

    filt_take_a: assert property (
        !filt_slow && !filt_four && q.fhist[0] == src_now |=> q.flevel == $past(src_now))
        else $error("filter missed two equal samples");

    filt_four_a: assert property (
        filt_four && q.fhist != {3{src_now}} |=> q.flevel == $past(q.flevel))
        else $error("filter took fewer than four samples");

    filt_slow_a: assert property (
        filt_slow && q.fdiv != `FILTER_SLOW_PHASE |=> q.fhist == $past(q.fhist))
        else $error("slow filter sampled off phase");

    edge_off_a: assert property (
        edge_sel == 2'h0 |-> !cap_evt)
        else $error("capture with edge select off");

    edge_rise_a: assert property (
        cap_evt && edge_sel == `EDGE_RISING |=> q.cond_prev && !$past(q.cond_prev))
        else $error("rising capture without rising edge");

    edge_fall_a: assert property (
        cap_evt && edge_sel == `EDGE_FALLING |=> !q.cond_prev && $past(q.cond_prev))
        else $error("falling capture without falling edge");

    reset_zero_a: assert property (
        disable iff (1'b0)
        !rst_n |=> q.ctl0 == 8'h00 && q.ctl1 == 8'h00 && q.cnt == 16'h0000 && rdata == 8'h00)
        else $error("reset left registers nonzero");

    clr_wins_a: assert property (
        clr |=> q.cnt == 16'h0000)
        else $error("auto-clear lost to count");

    cmp_zero_a: assert property (
        run && tick && q.cnt == 16'h0000 && q.cmp == 16'h0000 |=> compare_match_flag)
        else $error("zero compare value did not match");

    ovf_set_a: assert property (
        run && tick && q.cnt == `COUNTER_MAX && !clr |=> overflow_flag)
        else $error("wrap without overflow flag");

    match_tick_a: assert property (
        !(run && tick) |=> !compare_match_flag)
        else $error("match flag without counting tick");

    tick_only_a: assert property (
        timer_on && !tick && !clr && !ctl0_wr |=> q.cnt == $past(q.cnt))
        else $error("counter moved without tick");

    cap_hold_a: assert property (
        !cap_evt |=> q.cap == $past(q.cap))
        else $error("capture register changed without edge");

    cmp_write_a: assert property (
        wr_en && addr == `ADDR_COMPARE_HIGH_BYTE |=> q.cmp[15:8] == $past(wdata))
        else $error("compare high byte write lost");

    cmp_read_a: assert property (
        rd_en && addr == `ADDR_COMPARE_LOW_BYTE |=> {8'h00, rdata} == ($past(q.cmp) & 16'h00ff))
        else $error("compare low byte read wrong");

    cap_seen_c: cover property (cap_evt && cap_auto && timer_on);
    pause_seen_c: cover property (timer_on && pause && tick);
    match_seen_c: cover property (compare_match_flag && q.cmp == 16'h0000);
    ovf_seen_c: cover property (overflow_flag);
    filt_seen_c: cover property (timer_on && filt_en && filt_four && cap_evt);

endmodule

// file: tb/capture_source_model.sv
// Far-side model: Hall filter outputs, capture pin and PWM period line.
// Assumes the bench calls its tasks from one process, on clk.
`timescale 1ns/1ps

module capture_source_model (
    // Clock
    input  wire logic clk,
    // Sources
    output logic      hall_a_filtered,
    output logic      hall_b_filtered,
    output logic      hall_c_filtered,
    output logic      capture_pin_input,
    output logic      pwm_period_signal
);
    initial begin
        hall_a_filtered   = 1'b0;
        hall_b_filtered   = 1'b0;
        hall_c_filtered   = 1'b0;
        capture_pin_input = 1'b0;
        pwm_period_signal = 1'b0;
    end

    // Level held 6 clocks: covers sync, edge stage and capture write
    task automatic set_src(input int s, input logic v);
        @(posedge clk);
        case (s)
            0: hall_a_filtered <= v;
            1: hall_b_filtered <= v;
            2: hall_c_filtered <= v;
            default: capture_pin_input <= v;
        endcase
        repeat (6) @(posedge clk);
    endtask

    // Long high and low phases, so no tick is lost in the synchroniser
    task automatic pwm_pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            pwm_period_signal <= 1'b1;
            repeat (4) @(posedge clk);
            pwm_period_signal <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// file: tb/motor_capture_timer_tb.sv
// Self-checking bench of the capture timer with an integer model.
// Assumes the source model drives all capture and PWM inputs.
`timescale 1ns/1ps

module motor_capture_timer_tb;
    logic        clk;
    logic        rst_n;
    logic [2:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rdata;
    logic        ha, hb, hc, pin, pwm;
    logic        compare_match_flag;
    logic        overflow_flag;
    logic [15:0] r;
    int          n_errors, tests_run, cycles, cnt, cap, n, c, n_ovf;

    motor_capture_timer u_motor_capture_timer (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .hall_a_filtered(ha), .hall_b_filtered(hb),
        .hall_c_filtered(hc), .capture_pin_input(pin), .pwm_period_signal(pwm),
        .compare_match_flag(compare_match_flag), .overflow_flag(overflow_flag));

    capture_source_model u_capture_source_model (
        .clk(clk), .hall_a_filtered(ha), .hall_b_filtered(hb),
        .hall_c_filtered(hc), .capture_pin_input(pin), .pwm_period_signal(pwm));

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Reads a byte pair, low index first
    task automatic rchk(input logic [2:0] a, input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + 3'h1, hi);
        chk({hi, lo}, e);
    endtask

    task automatic wait_match(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (compare_match_flag !== 1'b1 && k < 2000);
    endtask

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, timeout, sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        // Counter never nears its top here, so no wrap is expected
        if (rst_n && overflow_flag !== 1'b0) begin
            n_ovf <= n_ovf + 1;
        end
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        {n_errors, tests_run, cycles, n_ovf} = '0;
        {rst_n, wr_en, rd_en, addr, wdata} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(55247));
        for (int a = 0; a < 8; a += 2) rchk(a[2:0], 16'h0000);
        wr(0, 8'hff);
        rchk(0, 16'h00fb);
        wr(0, 8'h00);
        r = 16'($urandom());
        wr(4, r[7:0]);
        wr(5, r[15:8]);
        rchk(4, r);
        for (int a = 2; a < 8; a++) if (a != 4 && a != 5) wr(a[2:0], 8'h5a);
        rchk(2, 16'h0000);
        rchk(6, 16'h0000);
        // Counter ticks only on PWM pulses here, so it is fully known
        wr(0, 8'h08);
        cnt = 0;
        cap = 0;
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 8; e++) begin
                wr(1, {e[1:0], e[2], 5'h00});
                wr(0, {6'h02, s[1:0]});
                n = $urandom_range(4, 1);
                u_capture_source_model.pwm_pulse(n);
                cnt += n;
                u_capture_source_model.set_src(s, 1'b1);
                if (e[2] && e[0]) cap = cnt;
                u_capture_source_model.pwm_pulse(1);
                cnt++;
                u_capture_source_model.set_src(s, 1'b0);
                if (e[2] && e[1]) cap = cnt;
                rchk(6, 16'(cap));
                rchk(2, 16'(cnt));
            end
        end
        wr(0, 8'h88);
        u_capture_source_model.pwm_pulse(3);
        rchk(2, 16'(cnt));
        wr(0, 8'h08);
        u_capture_source_model.pwm_pulse(2);
        rchk(2, 16'(cnt + 2));
        wr(1, 8'h62);
        wr(0, 8'h0b);
        u_capture_source_model.set_src(3, 1'b1);
        rchk(6, 16'(cnt + 2));
        rchk(2, 16'h0000);
        u_capture_source_model.pwm_pulse(2);
        wr(0, 8'h03);
        u_capture_source_model.pwm_pulse(2);
        rchk(2, 16'h0002);
        wr(0, 8'h08);
        rchk(2, 16'h0000);
        // Match period with auto-clear over every divider code
        wr(1, 8'h01);
        for (int k = 1; k < 8; k++) begin
            c = (k == 1) ? 0 : $urandom_range(3);
            wr(0, 8'h00);
            wr(4, c[7:0]);
            wr(5, 8'h00);
            wr(0, {1'b0, k[2:0], 4'h8});
            wait_match(n);
            wait_match(n);
            chk(16'(n), 16'((c + 1) << k));
        end
        chk(16'(n_ovf), 16'h0000);
        test_done();
    end
endmodule
